// *** hdl/rsvs_reset_sequencer.sv ***
/*
 * Reset sequencer with reset vector selection, pin defaults and register port.
 * Assumes all inputs except i_arst_n synchronous to i_clk; the reset pin is read via i_reset_pin.
 */
// Chosen here: the address-and-strobe port and the placing of the registers.
// Summary of operation
// - enter reset asynchronously on i_arst_n, at a clock edge otherwise; leave it synchronously to the clock
// - start sequence on power-on, watchdog, clock monitor or low reset pin
// - drive reset pin low open-drain on any reset; clocked sequence follows
// - power-on and clock-monitor resets wait 4096 cycles, pin held low
// - hold reset pin low 16 to 17 cycles, then release it
// - sample the reset pin nine cycles after release
// - pin still low: external reset, clear latches, normal vector
// - pin high with clock-monitor latch: clock-monitor vector, beats watchdog
// - pin high, watchdog latch only: watchdog vector
// - pin high, nothing latched: normal reset vector
// - mode from three straps in reset; pull-downs on lower two
// - maskable interrupt enabled, level triggered and masked at reset
// - nonmaskable mask set in reset until software clears it
// - interrupt pin pull-ups on until software clears pull-up enable
// - direction and low strobe pins come up as pulled-up inputs
// - data bus enable active in expanded modes, pulled up in single-chip
// - bus clock at half crystal; off single-chip user, on special single-chip
`timescale 1ns/1ps
module rsvs_reset_sequencer #(
    parameter int OSC_START_CYC = rsvs_pkg::OSC_START_CYC
) (
    input  wire logic                        i_clk,
    input  wire logic                        i_arst_n,
    input  wire logic                        i_watchdog_timeout,
    input  wire logic                        i_watchdog_en,
    input  wire logic                        i_clkmon_fail,
    input  wire logic                        i_clkmon_en,
    input  wire logic                        i_reset_pin,
    input  wire logic                        i_special_mode_strap,
    input  wire logic                        i_mode_strap_b,
    input  wire logic                        i_mode_strap_a,
    input  wire logic [rsvs_pkg::ADDR_W-1:0] i_addr,
    input  wire logic [rsvs_pkg::DATA_W-1:0] i_wdata,
    input  wire logic                        i_wr,
    input  wire logic                        i_rd,
    output logic      [rsvs_pkg::DATA_W-1:0] o_rdata,
    output logic                             o_irq,
    output logic                             o_cpu_reset_n,
    output logic      [15:0]                 o_vector,
    output logic      [2:0]                  o_mode,
    output logic                             o_reset_pin_out,
    output logic                             o_reset_pin_oe,
    output logic                             o_mode_pulldown,
    output logic                             o_int_pullup,
    output logic                             o_maskable_int_enable,
    output logic                             o_maskable_int_edge,
    output logic                             o_ccr_i_mask,
    output logic                             o_ccr_x_mask,
    output logic                             o_rw_func_en,
    output logic                             o_low_byte_strobe_en,
    output logic                             o_rw_low_byte_strobe_pullup,
    output logic                             o_data_bus_enable_func,
    output logic                             o_data_bus_enable_pullup,
    output logic                             o_bus_clock_out
);
    rsvs_pkg::rsvs_state_type state_reg, state_next;

    logic                          cnt_start;
    logic [rsvs_pkg::CNT_W-1:0]    cnt_load;
    logic                          cnt_done;
    logic                          wd_latch_reg;
    logic                          cm_latch_reg;
    logic                          wd_ev;
    logic                          cm_ev;
    logic                          decide;
    logic                          in_reset_next;
    logic                          single_chip;
    logic                          normal_single;
    logic [rsvs_pkg::CTL_W-1:0]    ctrl_reg;
    logic [rsvs_pkg::ST_W-1:0]     status_reg;
    logic [rsvs_pkg::ST_W-1:0]     status_set;
    logic [rsvs_pkg::ST_W-1:0]     status_clr;
    logic [rsvs_pkg::ST_W-1:0]     irq_en_reg;
    logic [12:0]                   osc_len;

    // events only count when their source is enabled
    assign wd_ev         = i_watchdog_timeout & i_watchdog_en;
    assign cm_ev         = i_clkmon_fail & i_clkmon_en;
    assign decide        = (state_reg == rsvs_pkg::S_WAIT) & cnt_done;
    assign in_reset_next = (state_next != rsvs_pkg::S_RUN);
    // decode the latched mode: straps serve other functions once running
    assign single_chip   = ~o_mode[1] & ~o_mode[0];
    assign normal_single = single_chip & o_mode[2];

    always_comb begin
        state_next = state_reg;
        cnt_start  = 1'b0;
        cnt_load   = rsvs_pkg::HOLD_CYC;
        unique case (state_reg)
            rsvs_pkg::S_INIT: begin
                state_next = rsvs_pkg::S_OSC;
                cnt_start  = 1'b1;
                cnt_load   = rsvs_pkg::CNT_W'(OSC_START_CYC);
            end
            rsvs_pkg::S_OSC: begin
                if (cnt_done) begin
                    state_next = rsvs_pkg::S_HOLD;
                    cnt_start  = 1'b1;
                end
            end
            rsvs_pkg::S_HOLD: begin
                if (cnt_done) begin
                    state_next = rsvs_pkg::S_WAIT;
                    cnt_start  = 1'b1;
                    cnt_load   = rsvs_pkg::SAMPLE_CYC;
                end
            end
            rsvs_pkg::S_WAIT: begin
                // a slow-rising pin here is read as an external reset
                if (cnt_done) begin
                    state_next = i_reset_pin ? rsvs_pkg::S_RUN : rsvs_pkg::S_EXT;
                end
            end
            rsvs_pkg::S_EXT: begin
                if (i_reset_pin) begin
                    state_next = rsvs_pkg::S_RUN;
                end
            end
            rsvs_pkg::S_RUN: begin
                if (cm_ev) begin
                    state_next = rsvs_pkg::S_OSC;
                    cnt_start  = 1'b1;
                    cnt_load   = rsvs_pkg::CNT_W'(OSC_START_CYC);
                end else if (wd_ev || !i_reset_pin) begin
                    state_next = rsvs_pkg::S_HOLD;
                    cnt_start  = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_reg <= rsvs_pkg::S_INIT;
        end else begin
            state_reg <= state_next;
        end
    end

    rsvs_down_counter #(
        .W (rsvs_pkg::CNT_W)
    ) u_counter (
        .i_clk    (i_clk),
        .i_arst_n (i_arst_n),
        .i_start  (cnt_start),
        .i_load   (cnt_load),
        .o_done   (cnt_done)
    );

    // reset asserts with i_arst_n alone, clockless; release waits for an edge
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_cpu_reset_n <= 1'b0;
        end else begin
            o_cpu_reset_n <= ~in_reset_next;
        end
    end

    // open-drain: data always low, only the enable moves
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_reset_pin_oe  <= 1'b1;
            o_reset_pin_out <= 1'b0;
        end else begin
            o_reset_pin_oe  <= (state_next == rsvs_pkg::S_INIT) | (state_next == rsvs_pkg::S_OSC)
                             | (state_next == rsvs_pkg::S_HOLD);
            o_reset_pin_out <= 1'b0;
        end
    end

    // failure latches survive the sequence; a new event beats the clear
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wd_latch_reg <= 1'b0;
            cm_latch_reg <= 1'b0;
        end else begin
            wd_latch_reg <= wd_ev | (wd_latch_reg & ~decide);
            cm_latch_reg <= cm_ev | (cm_latch_reg & ~decide);
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_vector <= rsvs_pkg::VEC_NORMAL;
        end else if (decide) begin
            if (!i_reset_pin) begin
                o_vector <= rsvs_pkg::VEC_NORMAL;
            end else if (cm_latch_reg) begin
                o_vector <= rsvs_pkg::VEC_CLKMON;
            end else if (wd_latch_reg) begin
                o_vector <= rsvs_pkg::VEC_WDOG;
            end else begin
                o_vector <= rsvs_pkg::VEC_NORMAL;
            end
        end else if (state_reg == rsvs_pkg::S_EXT) begin
            o_vector <= rsvs_pkg::VEC_NORMAL;
        end
    end

    // straps followed live during reset, frozen once the core runs
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_mode          <= 3'h0;
            o_mode_pulldown <= 1'b1;
        end else begin
            if (state_reg != rsvs_pkg::S_RUN) begin
                o_mode <= {i_special_mode_strap, i_mode_strap_b, i_mode_strap_a};
            end
            o_mode_pulldown <= in_reset_next;
        end
    end

    // control register: defaults forced throughout reset
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ctrl_reg <= '0;
            ctrl_reg[rsvs_pkg::CTL_PULLUP_EN] <= 1'b1;
            ctrl_reg[rsvs_pkg::CTL_MINT_EN]   <= 1'b1;
            ctrl_reg[rsvs_pkg::CTL_CCR_I]     <= 1'b1;
            ctrl_reg[rsvs_pkg::CTL_CCR_X]     <= 1'b1;
        end else if (state_reg != rsvs_pkg::S_RUN) begin
            ctrl_reg <= '0;
            ctrl_reg[rsvs_pkg::CTL_BUS_CLOCK_OUT_EN]   <= ~normal_single;
            ctrl_reg[rsvs_pkg::CTL_PULLUP_EN] <= 1'b1;
            ctrl_reg[rsvs_pkg::CTL_MINT_EN]   <= 1'b1;
            ctrl_reg[rsvs_pkg::CTL_CCR_I]     <= 1'b1;
            ctrl_reg[rsvs_pkg::CTL_CCR_X]     <= 1'b1;
        end else if (i_wr && i_addr == rsvs_pkg::OFS_CTRL) begin
            ctrl_reg[rsvs_pkg::CTL_CCR_I:0] <= i_wdata[rsvs_pkg::CTL_CCR_I:0];
            // the x mask can be cleared by software but never set again
            ctrl_reg[rsvs_pkg::CTL_CCR_X] <= ctrl_reg[rsvs_pkg::CTL_CCR_X]
                                           & i_wdata[rsvs_pkg::CTL_CCR_X];
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_maskable_int_enable    <= 1'b1;
            o_maskable_int_edge      <= 1'b0;
            o_ccr_i_mask             <= 1'b1;
            o_ccr_x_mask             <= 1'b1;
            o_int_pullup             <= 1'b1;
            o_rw_func_en             <= 1'b0;
            o_low_byte_strobe_en     <= 1'b0;
            o_rw_low_byte_strobe_pullup        <= 1'b1;
            o_data_bus_enable_func   <= 1'b0;
            o_data_bus_enable_pullup <= 1'b1;
        end else begin
            o_maskable_int_enable    <= ctrl_reg[rsvs_pkg::CTL_MINT_EN] | in_reset_next;
            o_maskable_int_edge      <= ctrl_reg[rsvs_pkg::CTL_MINT_EDGE] & ~in_reset_next;
            o_ccr_i_mask             <= ctrl_reg[rsvs_pkg::CTL_CCR_I] | in_reset_next;
            o_ccr_x_mask             <= ctrl_reg[rsvs_pkg::CTL_CCR_X] | in_reset_next;
            o_int_pullup             <= ctrl_reg[rsvs_pkg::CTL_PULLUP_EN] | in_reset_next;
            o_rw_func_en             <= ctrl_reg[rsvs_pkg::CTL_RW_EN] & ~in_reset_next;
            o_low_byte_strobe_en     <= ctrl_reg[rsvs_pkg::CTL_LOW_BYTE_STROBE_EN] & ~in_reset_next;
            o_rw_low_byte_strobe_pullup        <= ~(ctrl_reg[rsvs_pkg::CTL_RW_EN] & ctrl_reg[rsvs_pkg::CTL_LOW_BYTE_STROBE_EN])
                                      | in_reset_next;
            o_data_bus_enable_func   <= ~single_chip & (~ctrl_reg[rsvs_pkg::CTL_DBE_OFF] | in_reset_next);
            o_data_bus_enable_pullup <= single_chip;
        end
    end

    rsvs_bus_clock u_bus_clock (
        .i_clk     (i_clk),
        .i_arst_n  (i_arst_n),
        .i_en      (ctrl_reg[rsvs_pkg::CTL_BUS_CLOCK_OUT_EN]),
        .o_clk_out (o_bus_clock_out)
    );

    // sticky status: hardware set wins over a software clear
    always_comb begin
        status_set = '0;
        status_set[rsvs_pkg::ST_POR]      = (state_reg == rsvs_pkg::S_INIT);
        status_set[rsvs_pkg::ST_WDOG]     = wd_ev;
        status_set[rsvs_pkg::ST_CLKMON]   = cm_ev;
        status_set[rsvs_pkg::ST_EXTERNAL] = decide & ~i_reset_pin;
        status_set[rsvs_pkg::ST_RELEASE]  = in_reset_next == 1'b0 && state_reg != rsvs_pkg::S_RUN;
        status_clr = (i_wr && i_addr == rsvs_pkg::OFS_CLEAR) ? i_wdata[rsvs_pkg::ST_W-1:0] : '0;
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            status_reg <= '0;
            irq_en_reg <= '0;
            o_irq      <= 1'b0;
        end else begin
            status_reg <= status_set | (status_reg & ~status_clr);
            if (i_wr && i_addr == rsvs_pkg::OFS_IRQ_EN) begin
                irq_en_reg <= i_wdata[rsvs_pkg::ST_W-1:0];
            end
            o_irq <= |(status_reg & irq_en_reg);
        end
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rdata <= '0;
        end else if (i_rd) begin
            unique case (i_addr)
                rsvs_pkg::OFS_CTRL:   o_rdata <= {{(rsvs_pkg::DATA_W-rsvs_pkg::CTL_W){1'b0}}, ctrl_reg};
                rsvs_pkg::OFS_STATUS: o_rdata <= {{(rsvs_pkg::DATA_W-rsvs_pkg::ST_W){1'b0}}, status_reg};
                rsvs_pkg::OFS_IRQ_EN: o_rdata <= {{(rsvs_pkg::DATA_W-rsvs_pkg::ST_W){1'b0}}, irq_en_reg};
                rsvs_pkg::OFS_INFO:   o_rdata <= {5'h00, cm_latch_reg, wd_latch_reg, o_mode, state_reg, o_vector};
                default:              o_rdata <= '0;
            endcase
        end else begin
            o_rdata <= '0;
        end
    end

    // helper for the start-up delay check
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            osc_len <= 13'h0000;
        end else begin
            osc_len <= (state_reg == rsvs_pkg::S_OSC) ? osc_len + 13'h0001 : 13'h0000;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);

    sequence s_pin_held_16;
        o_reset_pin_oe[*8] ##1 o_reset_pin_oe[*8];
    endsequence
    sequence s_then_release;
        o_reset_pin_oe ##1 !o_reset_pin_oe;
    endsequence

    a_hold_pin_low: assert property ($rose(state_reg == rsvs_pkg::S_HOLD) |-> s_pin_held_16 ##1 s_then_release)
        else $error("reset pin hold length wrong");
    a_sample_nine_late: assert property ($fell(o_reset_pin_oe) |-> ##9 decide)
        else $error("reset pin not sampled nine cycles after release");
    a_osc_start_delay: assert property (state_reg == rsvs_pkg::S_OSC && cnt_done |-> osc_len == 13'(OSC_START_CYC) && o_reset_pin_oe)
        else $error("start-up delay length wrong");
    a_clkmon_vector: assert property (decide && i_reset_pin && cm_latch_reg |=> o_vector == rsvs_pkg::VEC_CLKMON)
        else $error("clock monitor vector not chosen");
    a_wdog_vector: assert property (decide && i_reset_pin && !cm_latch_reg && wd_latch_reg |=> o_vector == rsvs_pkg::VEC_WDOG)
        else $error("watchdog vector not chosen");
    a_ext_clears: assert property (decide && !i_reset_pin && !wd_ev && !cm_ev |=> !wd_latch_reg && !cm_latch_reg && o_vector == rsvs_pkg::VEC_NORMAL)
        else $error("external reset did not clear latches");
    a_reset_held: assert property (state_reg != rsvs_pkg::S_RUN && $past(state_reg) != rsvs_pkg::S_RUN |-> !o_cpu_reset_n)
        else $error("core released during sequence");
    a_pullups_reset: assert property (!o_cpu_reset_n |-> o_int_pullup && o_mode_pulldown && o_ccr_x_mask && !o_rw_func_en)
        else $error("reset pin defaults wrong");
    a_xmask_sticky: assert property (o_cpu_reset_n && $past(o_cpu_reset_n) |-> !$rose(o_ccr_x_mask))
        else $error("x mask set by software");
    a_set_wins: assert property (wd_ev && i_wr && i_addr == rsvs_pkg::OFS_CLEAR |=> status_reg[rsvs_pkg::ST_WDOG])
        else $error("status set lost to clear");

endmodule

// *** hdl/rsvs_pkg.sv ***
/*
 * Shared constants for the reset sequencer: register map, control and
 * status bit positions, reset vectors, sequence timing and state codes.
 * Assumes a 50 MHz oscillator clock that also serves as the crystal clock.
 */
package rsvs_pkg;

    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 32;
    localparam int          CNT_W         = 13;

    // register byte offsets
    localparam logic [7:0]  OFS_CTRL      = 8'h00;
    localparam logic [7:0]  OFS_STATUS    = 8'h04;
    localparam logic [7:0]  OFS_CLEAR     = 8'h08;
    localparam logic [7:0]  OFS_IRQ_EN    = 8'h0c;
    localparam logic [7:0]  OFS_INFO      = 8'h10;

    // control register fields
    localparam int          CTL_BUS_CLOCK_OUT_EN   = 0;
    localparam int          CTL_PULLUP_EN = 1;
    localparam int          CTL_MINT_EN   = 2;
    localparam int          CTL_MINT_EDGE = 3;
    localparam int          CTL_RW_EN     = 4;
    localparam int          CTL_LOW_BYTE_STROBE_EN  = 5;
    localparam int          CTL_DBE_OFF   = 6;
    localparam int          CTL_CCR_I     = 7;
    localparam int          CTL_CCR_X     = 8;
    localparam int          CTL_W         = 9;

    // status / clear / enable fields
    localparam int          ST_POR        = 0;
    localparam int          ST_WDOG       = 1;
    localparam int          ST_CLKMON     = 2;
    localparam int          ST_EXTERNAL   = 3;
    localparam int          ST_RELEASE    = 4;
    localparam int          ST_W          = 5;

    // reset vectors (address of high byte)
    localparam logic [15:0] VEC_NORMAL    = 16'hfffe;
    localparam logic [15:0] VEC_CLKMON    = 16'hfffc;
    localparam logic [15:0] VEC_WDOG      = 16'hfffa;

    // sequence timing in oscillator cycles
    localparam int          OSC_START_CYC = 4096;
    localparam logic [12:0] HOLD_CYC      = 13'h0010;
    localparam logic [12:0] SAMPLE_CYC    = 13'h0009;

    typedef enum logic [5:0] {
        S_INIT = 6'h01,
        S_OSC  = 6'h02,
        S_HOLD = 6'h04,
        S_WAIT = 6'h08,
        S_EXT  = 6'h10,
        S_RUN  = 6'h20
    } rsvs_state_type;

endpackage

// *** hdl/rsvs_down_counter.sv ***
/*
 * Loadable down-counter: a start pulse loads a count, and o_done pulses
 * for one cycle exactly that many cycles after the start cycle ends.
 * Assumes one clock and an asynchronous active-low reset.
 */
`timescale 1ns/1ps
module rsvs_down_counter #(
    parameter int W = 13
) (
    input  wire logic         i_clk,
    input  wire logic         i_arst_n,
    input  wire logic         i_start,
    input  wire logic [W-1:0] i_load,
    output logic              o_done
);
    logic [W-1:0] cnt_reg;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cnt_reg <= '0;
            o_done  <= 1'b0;
        end else if (i_start) begin
            cnt_reg <= i_load;
            o_done  <= 1'b0;
        end else if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 1'b1;
            o_done  <= (cnt_reg == {{(W-1){1'b0}}, 1'b1});
        end else begin
            o_done  <= 1'b0;
        end
    end
endmodule

// *** hdl/rsvs_bus_clock.sv ***
/*
 * Bus clock output: toggles every crystal cycle while enabled, giving half
 * the crystal rate; parked low while disabled. Output is a flip-flop.
 * Assumes i_clk is the crystal clock.
 */
`timescale 1ns/1ps
module rsvs_bus_clock (
    input  wire logic i_clk,
    input  wire logic i_arst_n,
    input  wire logic i_en,
    output logic      o_clk_out
);
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_clk_out <= 1'b0;
        end else begin
            o_clk_out <= i_en ? ~o_clk_out : 1'b0;
        end
    end
endmodule

// *** tb/rsvs_pin_model.sv ***
/* Far side of the reset pin: board pull-up plus an external low driver.
   Assumes the device pulls the pin low open-drain while its enable is high. */
`timescale 1ns/1ps
module rsvs_pin_model (
    input  wire logic i_oe,
    input  wire logic i_ext_low,
    output logic      o_pin
);
    // strong pull-up: rises at once, well inside the sampling delay
    assign o_pin = !(i_oe || i_ext_low);
endmodule

// *** tb/reset_sequencer_vector_select_test.sv ***
/* Self-checking bench for the reset sequencer.
   Assumes the pin model as far side and a shortened start-up delay. */
`timescale 1ns/1ps
module reset_sequencer_vector_select_test;
    localparam int OSC = 16;
    logic i_clk = 0, i_arst_n = 0, i_watchdog_timeout = 0, i_watchdog_en = 1, i_clkmon_fail = 0;
    logic i_clkmon_en = 1, i_special_mode_strap = 1, i_mode_strap_b = 0, i_mode_strap_a = 0;
    logic i_wr = 0, i_rd = 0, ext_low = 0, o_irq, o_cpu_reset_n, o_reset_pin_out, o_reset_pin_oe;
    logic o_mode_pulldown, o_int_pullup, o_maskable_int_enable, o_maskable_int_edge, o_ccr_i_mask;
    logic o_ccr_x_mask, o_rw_func_en, o_low_byte_strobe_en, o_rw_low_byte_strobe_pullup, o_bus_clock_out;
    logic o_data_bus_enable_func, o_data_bus_enable_pullup;
    logic [7:0]  i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0, o_rdata, d;
    logic [15:0] o_vector;
    logic [2:0]  o_mode;
    wire         i_reset_pin;
    int          miscompares = 0, num_checks = 0;
    wire [11:0]  pins = {o_mode_pulldown, o_int_pullup, o_maskable_int_enable, o_maskable_int_edge,
        o_ccr_i_mask, o_ccr_x_mask, o_rw_func_en, o_low_byte_strobe_en, o_rw_low_byte_strobe_pullup,
        o_data_bus_enable_func, o_data_bus_enable_pullup, o_bus_clock_out};

    rsvs_pin_model pm (.i_oe(o_reset_pin_oe), .i_ext_low(ext_low), .o_pin(i_reset_pin));
    rsvs_reset_sequencer #(.OSC_START_CYC(OSC)) dut (.i_clk, .i_arst_n, .i_watchdog_timeout,
        .i_watchdog_en, .i_clkmon_fail, .i_clkmon_en, .i_reset_pin, .i_special_mode_strap,
        .i_mode_strap_b, .i_mode_strap_a, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_irq,
        .o_cpu_reset_n, .o_vector, .o_mode, .o_reset_pin_out, .o_reset_pin_oe, .o_mode_pulldown,
        .o_int_pullup, .o_maskable_int_enable, .o_maskable_int_edge, .o_ccr_i_mask, .o_ccr_x_mask,
        .o_rw_func_en, .o_low_byte_strobe_en, .o_rw_low_byte_strobe_pullup, .o_data_bus_enable_func,
        .o_data_bus_enable_pullup, .o_bus_clock_out);

    initial forever #10 i_clk = ~i_clk;

    task automatic stop_test;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("Error t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge i_clk) {i_wr, i_addr, i_wdata} <= {1'b1, a, v};
        @(posedge i_clk) i_wr <= 0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge i_clk) {i_rd, i_addr} <= {1'b1, a};
        @(posedge i_clk) i_rd <= 0;
        @(negedge i_clk) d = o_rdata;
    endtask

    task automatic ev(input logic w, input logic c);
        @(posedge i_clk) {i_watchdog_timeout, i_clkmon_fail} <= {w, c};
        @(posedge i_clk) {i_watchdog_timeout, i_clkmon_fail} <= 2'b00;
    endtask

    // counts pin-drive and sampling cycles until the core is released
    task automatic run_seq(input bit osc, input logic [15:0] v, input int w);
        int n_oe = 0, n_w = 0;
        repeat (300) begin
            @(negedge i_clk);
            if (o_cpu_reset_n === 1'b1) break;
            if (o_reset_pin_oe) n_oe++;
            else n_w++;
        end
        if (o_cpu_reset_n !== 1'b1) begin
            miscompares++;
            stop_test;
        end
        chk(osc ? n_oe >= OSC + 16 : n_oe inside {16, 17}, 1);
        if (w > 0) chk(n_w, w);
        chk(o_vector, v);
    endtask

    task automatic por(input logic [2:0] m, input logic [11:0] p, input logic ck);
        logic b;
        @(posedge i_clk) {i_arst_n, i_special_mode_strap, i_mode_strap_b, i_mode_strap_a} <= {1'b0, m};
        repeat (5) @(posedge i_clk);
        // async reset values are fixed, whatever the straps say
        @(negedge i_clk) chk({pins, o_reset_pin_oe, o_cpu_reset_n}, {12'heca, 2'b10});
        @(posedge i_clk) i_arst_n <= 1;
        run_seq(1, 16'hfffe, 10);
        chk(o_mode, m);
        chk(pins[10:1], p[10:1]);
        b = o_bus_clock_out;
        @(negedge i_clk) chk(o_bus_clock_out != b, ck);
    endtask

    initial begin
        por(3'b101, 12'hecc, 1);
        por(3'b000, 12'heca, 1);
        por(3'b100, 12'heca, 0);
        chk(o_irq, 0);
        @(posedge i_clk) {i_watchdog_en, i_clkmon_en} <= 2'b00;
        ev(1, 1);
        repeat (3) @(negedge i_clk) chk(o_cpu_reset_n, 1);
        @(posedge i_clk) {i_watchdog_en, i_clkmon_en} <= 2'b11;
        wr(rsvs_pkg::OFS_IRQ_EN, 32'h2);
        ev(1, 0);
        run_seq(0, 16'hfffa, 10);
        chk(o_irq, 1);
        wr(rsvs_pkg::OFS_CLEAR, 32'h1f);
        repeat (2) @(negedge i_clk);
        chk(o_irq, 0);
        ev(1, 1);
        run_seq(1, 16'hfffc, 10);
        ext_low <= 1;
        fork
            run_seq(0, 16'hfffe, 0);
            ev(1, 0);
            begin repeat (40) @(posedge i_clk); ext_low <= 0; end
        join
        rd(rsvs_pkg::OFS_INFO);
        chk(d[26:25], 0);
        rd(rsvs_pkg::OFS_STATUS);
        chk(d[rsvs_pkg::ST_EXTERNAL], 1);
        rd(8'h20);
        chk(d, 0);
        wr(rsvs_pkg::OFS_CTRL, 32'h0);
        repeat (2) @(negedge i_clk);
        chk({o_ccr_x_mask, o_int_pullup, o_reset_pin_out}, 0);
        wr(rsvs_pkg::OFS_CLEAR, 32'h1f);
        // watchdog event and its clear in one cycle: the event must stay
        fork
            ev(1, 0);
            wr(rsvs_pkg::OFS_CLEAR, 32'h2);
        join
        rd(rsvs_pkg::OFS_STATUS);
        chk(d[rsvs_pkg::ST_WDOG], 1);
        stop_test;
    end
endmodule
